// *** design/seep_pkg.sv ***
// Purpose: Shared constants and types of the two-wire serial EEPROM slave.
// Assumes: System clock of 25 MHz; serial clock comes from the bus host.
// Notes: Every field position, the address and strap reset values and each timing count are named here once.

package seep_pkg;

	// ----------------------------------------------------------------
	// Array geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8; // Word address width
	localparam int DATA_W = 8; // Byte width
	localparam int WORDS = 256; // Bytes in the array
	localparam int PAGE_BYTES = 8; // Bytes in one page
	localparam int PAGES = 32; // Pages in the array
	localparam int PAGE_OFS_W = 3; // Offset bits inside a page
	localparam logic [3:0] PAGE_END = 4'h8; // Walk index past the last byte

	// ----------------------------------------------------------------
	// Device-select byte layout
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_PREFIX = 4'ha; // Fixed one-zero pattern
	localparam int SEL_PREFIX_POS = 4; // Low bit of the fixed pattern
	localparam int SEL_BITS_POS = 1; // Low bit of the three select bits
	localparam int RW_POS = 0; // Read/write bit, one means read

	// ----------------------------------------------------------------
	// Bit timing inside one byte frame
	// ----------------------------------------------------------------
	localparam logic [3:0] LAST_DATA_BIT = 4'h7; // Clock of the eighth bit
	localparam logic [3:0] ACK_BIT = 4'h8; // Ninth clock, acknowledge slot
	localparam logic [3:0] FIRST_BIT_AFTER_START = 4'h1; // Bit count after first clock

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_RST = 8'h00; // Word address counter
	localparam logic [2:0] SEL_RST = 3'h0; // Strap copies before first frame

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_FREQ_HZ = 25000000; // System clock rate
	localparam int INTERNAL_PROGRAM_TIME_MS = 5; // Longest programming time
	localparam int PROG_CYCLES_DEF = INTERNAL_PROGRAM_TIME_MS * (CLK_FREQ_HZ / 1000);
	localparam int PROG_MARGIN = 16; // Cycles kept free for the array drain
	localparam int BUF_DEPTH = 2; // Entries of the write buffer

	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LS_IDLE,
		LS_DEV,
		LS_WORD,
		LS_WDATA,
		LS_READ
	} seep_link_state_type;

	typedef enum logic {
		PS_IDLE,
		PS_RUN
	} seep_prog_state_type;

endpackage

// *** design/seep_buf.sv ***
// Purpose: Small synchronous buffer with valid and ready on both sides.
// Assumes: One clock; depth is a power of two of at least two.
// Notes: Full and empty come from an entry count, never from a guess.

`timescale 1ns/1ps
`default_nettype none

module seep_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Filling side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Draining side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
		$error("seep_buf depth must be a power of two, at least two");
	end

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] slot_q [0:DEPTH-1]; // Entry storage
	logic [PW-1:0] wr_ptr_q, wr_ptr_d; // Next slot to fill
	logic [PW-1:0] rd_ptr_q, rd_ptr_d; // Next slot to drain
	logic [PW:0] count_q, count_d; // Entries held
	logic push; // Word taken on the filling side
	logic pop; // Word taken on the draining side

	// Honest flags straight from the count
	assign in_ready_out = (count_q != (PW + 1)'(DEPTH));
	assign out_valid_out = (count_q != '0);
	assign out_data_out = slot_q[rd_ptr_q];

	// Next pointer and count values
	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
		rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end

	// Pointer registers, frozen while the enable is low
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (ce_in) begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			count_q <= count_d;
		end
	end

	// Data slots need no reset; valid guards every read
	always_ff @(posedge clk_in) begin
		if (ce_in && push) begin
			slot_q[wr_ptr_q] <= in_data_in;
		end
	end

endmodule

`default_nettype wire

// *** design/seep_top.sv ***
// Purpose: Device side of a two-wire serial EEPROM of 256 bytes.
// Assumes: Serial clock drives the link logic; clk_in runs the program cycle.
// Notes: Stored bytes change only at the end of the self-timed program cycle.
//
// Summary of operation
// - Sample on rising clock, drive on falling.
// - Data line only pulled low or released.
// - Three select straps give eight bus identities.
// - Write protect high blocks every array change.
// - Write protect low allows normal reads, writes.
// - Array holds 256 bytes of 8 bits.
// - Thirty-two pages of eight bytes each.
// - One 8-bit word address selects any byte.
// - Page writes up to eight bytes, partial allowed.
// - Self-timed program cycle ends within 5 ms.
// - Start and stop are data edges, clock high.
// - Eight-bit bytes, acknowledged low on ninth clock.
// - Select byte: 1010, three select bits, read/write.
// - Page writes wrap the low three address bits.

`timescale 1ns/1ps
`default_nettype none

module seep_top #(
	parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES_DEF
) (
	// System clock, reset and enable
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Straps
	input wire logic dev_sel_bit0_pin_in,
	input wire logic dev_sel_bit1_pin_in,
	input wire logic dev_sel_bit2_pin_in,
	input wire logic wp_in,
	// Status
	output logic prog_busy_out
);

	// ----------------------------------------------------------------
	// Elaboration checks and derived sizes
	// ----------------------------------------------------------------
	localparam int TW = $clog2(PROG_CYCLES + 1);
	localparam int PROG_TARGET = PROG_CYCLES - seep_pkg::PROG_MARGIN;
	localparam int ENTRY_W = seep_pkg::ADDR_W + seep_pkg::DATA_W;

	if (PROG_CYCLES <= 2 * seep_pkg::PROG_MARGIN) begin : g_bad_prog
		$error("seep_top program cycle count too small for the drain margin");
	end

	// Select byte decode: fixed pattern and strap compare
	function automatic logic sel_match(input logic [7:0] b, input logic [2:0] sel);
		sel_match = (b[7:seep_pkg::SEL_PREFIX_POS] == seep_pkg::SEL_PREFIX)
			&& (b[seep_pkg::SEL_BITS_POS+:3] == sel);
	endfunction

	// ----------------------------------------------------------------
	// Array storage
	// ----------------------------------------------------------------
	logic [7:0] mem_q [0:seep_pkg::WORDS-1]; // 256 bytes, 32 pages of 8

	// ----------------------------------------------------------------
	// Start and stop detection on data edges
	// ----------------------------------------------------------------
	logic start_tog_q, start_tog_d; // Flips on each start
	logic stop_tog_q, stop_tog_d; // Flips on each stop

	// Start: data falls while clock is high
	always_comb begin
		start_tog_d = scl_in ? ~start_tog_q : start_tog_q;
	end

	// Stop: data rises while clock is high
	always_comb begin
		stop_tog_d = scl_in ? ~stop_tog_q : stop_tog_q;
	end

	// Data line acts as clock only for these two toggles
	always_ff @(negedge sda_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			start_tog_q <= 1'b0;
		end else begin
			start_tog_q <= start_tog_d;
		end
	end

	always_ff @(posedge sda_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			stop_tog_q <= 1'b0;
		end else begin
			stop_tog_q <= stop_tog_d;
		end
	end

	// ----------------------------------------------------------------
	// Strap synchronisers on the serial clock
	// ----------------------------------------------------------------
	logic [3:0] pin_raw; // Write protect and three select straps
	logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q; // Three-stage chains
	logic [3:0] pin_st_q, pin_st_d; // Accepted strap levels
	logic [2:0] sel_q; // Accepted select straps
	logic wp_q; // Accepted write protect

	assign pin_raw = {wp_in, dev_sel_bit2_pin_in, dev_sel_bit1_pin_in, dev_sel_bit0_pin_in};
	assign sel_q = pin_st_q[2:0];
	assign wp_q = pin_st_q[3];

	// A strap change counts once stages two and three agree
	for (genvar g = 0; g < 4; g++) begin : g_pin
		always_comb begin
			pin_st_d[g] = (pin_s2_q[g] == pin_s3_q[g]) ? pin_s3_q[g] : pin_st_q[g];
		end
	end

	always_ff @(posedge scl_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			pin_st_q <= {1'b0, seep_pkg::SEL_RST};
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_st_q <= pin_st_d;
		end
	end

	// ----------------------------------------------------------------
	// Link state on the rising serial clock
	// ----------------------------------------------------------------
	seep_pkg::seep_link_state_type state_q, state_d; // Byte role in frame
	logic [3:0] bit_q, bit_d; // Clock count inside a byte, 8 is ack
	logic [6:0] shift_q, shift_d; // Bits received so far
	logic ack_q, ack_d; // We acknowledge this byte
	logic rw_q, rw_d; // Read requested
	logic [7:0] addr_q, addr_d; // Word address counter
	logic [7:0] rd_q, rd_d; // Byte being sent
	logic [4:0] page_q, page_d; // Page of the pending write
	logic [7:0] mask_q, mask_d; // Bytes of the page that were sent
	logic [7:0] pdata_q [0:seep_pkg::PAGE_BYTES-1]; // Pending page bytes
	logic [7:0] pdata_d [0:seep_pkg::PAGE_BYTES-1];
	logic frame_wr_q, frame_wr_d; // Frame holds data to program
	logic seen_q, seen_d; // Last start toggle acted upon
	logic busy_s1_q, busy_s2_q; // Program busy, synchronised
	logic [7:0] nb; // Byte completed on this clock
	logic [7:0] rd_next_addr; // Address after a sent byte
	logic busy_q; // Program cycle running, system domain

	// Next link values; the array is read here while it is quiescent
	always_comb begin
		nb = {shift_q, sda_in};
		rd_next_addr = addr_q + 8'h01;
		state_d = state_q;
		bit_d = bit_q;
		shift_d = shift_q;
		ack_d = ack_q;
		rw_d = rw_q;
		addr_d = addr_q;
		rd_d = rd_q;
		page_d = page_q;
		mask_d = mask_q;
		pdata_d = pdata_q;
		frame_wr_d = frame_wr_q;
		seen_d = seen_q;
		if (start_tog_q != seen_q) begin
			// First clock after a start holds the first select bit
			seen_d = start_tog_q;
			state_d = seep_pkg::LS_DEV;
			bit_d = seep_pkg::FIRST_BIT_AFTER_START;
			shift_d = {6'h00, sda_in};
			ack_d = 1'b0;
		end else if (state_q != seep_pkg::LS_IDLE && bit_q != seep_pkg::ACK_BIT) begin
			shift_d = nb[6:0];
			bit_d = bit_q + 4'h1;
			if (bit_q == seep_pkg::LAST_DATA_BIT) begin
				case (state_q)
					seep_pkg::LS_DEV: begin
						// Ignore the bus while programming runs
						ack_d = sel_match(nb, sel_q) && !busy_s2_q;
						rw_d = nb[seep_pkg::RW_POS];
						frame_wr_d = 1'b0;
						rd_d = mem_q[addr_q];
					end
					seep_pkg::LS_WORD: begin
						// Word address latched; a new page write starts empty
						ack_d = 1'b1;
						addr_d = nb;
						page_d = nb[7:seep_pkg::PAGE_OFS_W];
						mask_d = 8'h00;
					end
					seep_pkg::LS_WDATA: begin
						ack_d = 1'b1;
						if (!wp_q) begin
							// Only bytes sent are marked for programming
							pdata_d[addr_q[2:0]] = nb;
							mask_d[addr_q[2:0]] = 1'b1;
							frame_wr_d = 1'b1;
						end
						// Low three bits wrap inside the page
						addr_d = {addr_q[7:3], addr_q[2:0] + 3'h1};
					end
					default: begin
						// Read byte: the host answers, not us
						ack_d = 1'b0;
					end
				endcase
			end
		end else if (state_q != seep_pkg::LS_IDLE) begin
			// Ninth clock closes the byte
			bit_d = 4'h0;
			case (state_q)
				seep_pkg::LS_DEV: begin
					if (!ack_q) begin
						state_d = seep_pkg::LS_IDLE;
					end else if (rw_q) begin
						state_d = seep_pkg::LS_READ;
					end else begin
						state_d = seep_pkg::LS_WORD;
					end
				end
				seep_pkg::LS_WORD: begin
					state_d = seep_pkg::LS_WDATA;
				end
				seep_pkg::LS_WDATA: begin
					state_d = seep_pkg::LS_WDATA;
				end
				seep_pkg::LS_READ: begin
					// Reads roll over the whole array
					addr_d = rd_next_addr;
					rd_d = mem_q[rd_next_addr];
					if (sda_in) begin
						state_d = seep_pkg::LS_IDLE;
					end
				end
				default: begin
					state_d = seep_pkg::LS_IDLE;
				end
			endcase
		end
	end

	// Link registers; page bytes keep no reset, the mask guards them
	always_ff @(posedge scl_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= seep_pkg::LS_IDLE;
			bit_q <= 4'h0;
			shift_q <= 7'h00;
			ack_q <= 1'b0;
			rw_q <= 1'b0;
			addr_q <= seep_pkg::ADDR_RST;
			rd_q <= 8'h00;
			page_q <= 5'h00;
			mask_q <= 8'h00;
			frame_wr_q <= 1'b0;
			seen_q <= 1'b0;
			busy_s1_q <= 1'b0;
			busy_s2_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			ack_q <= ack_d;
			rw_q <= rw_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			page_q <= page_d;
			mask_q <= mask_d;
			frame_wr_q <= frame_wr_d;
			seen_q <= seen_d;
			busy_s1_q <= busy_q;
			busy_s2_q <= busy_s1_q;
		end
	end

	always_ff @(posedge scl_in) begin
		pdata_q <= pdata_d;
	end

	// ----------------------------------------------------------------
	// Data line drive on the falling serial clock
	// ----------------------------------------------------------------
	logic oe_q, oe_d; // Pull the data line low

	// Low for an acknowledge or a zero read bit, else released
	always_comb begin
		oe_d = 1'b0;
		if (state_q == seep_pkg::LS_READ && bit_q != seep_pkg::ACK_BIT) begin
			oe_d = ~rd_q[~bit_q[2:0]];
		end else if (state_q != seep_pkg::LS_IDLE && state_q != seep_pkg::LS_READ
			&& bit_q == seep_pkg::ACK_BIT && ack_q) begin
			oe_d = 1'b1;
		end
	end

	// Driven level is always zero: open drain
	always_ff @(negedge scl_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			oe_q <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			oe_q <= oe_d;
			sda_out <= 1'b0;
		end
	end

	assign sda_oe_out = oe_q;

	// ----------------------------------------------------------------
	// Program cycle in the system clock domain
	// ----------------------------------------------------------------
	seep_pkg::seep_prog_state_type pst_q, pst_d; // Program sequencer
	logic [2:0] stop_s_q; // Stop toggle synchroniser
	logic [1:0] fw_s_q; // Write-pending synchroniser
	logic [TW-1:0] timer_q, timer_d; // Elapsed program cycles
	logic tdone_q, tdone_d; // Cells have settled
	logic [3:0] idx_q, idx_d; // Page walk index
	logic busy_d;
	logic stop_ev; // One cycle per stop on the bus
	logic push_valid, push_ready, pop_valid, pop_ready;
	logic [ENTRY_W-1:0] push_data, pop_data;

	assign stop_ev = stop_s_q[2] ^ stop_s_q[1];

	// Page latch is read here only while the link ignores the bus
	always_comb begin
		pst_d = pst_q;
		timer_d = timer_q;
		tdone_d = tdone_q;
		idx_d = idx_q;
		busy_d = busy_q;
		push_valid = 1'b0;
		push_data = {page_q, idx_q[2:0], pdata_q[idx_q[2:0]]};
		pop_ready = 1'b0;
		case (pst_q)
			seep_pkg::PS_IDLE: begin
				// A stop ending a write with data starts the cycle
				if (stop_ev && fw_s_q[1]) begin
					pst_d = seep_pkg::PS_RUN;
					busy_d = 1'b1;
					timer_d = '0;
					tdone_d = 1'b0;
					idx_d = 4'h0;
				end
			end
			seep_pkg::PS_RUN: begin
				if (!tdone_q) begin
					timer_d = timer_q + 1'b1;
					tdone_d = (timer_q == TW'(PROG_TARGET));
				end
				pop_ready = tdone_q;
				if (idx_q != seep_pkg::PAGE_END) begin
					push_valid = mask_q[idx_q[2:0]];
					if (!push_valid || push_ready) begin
						idx_d = idx_q + 4'h1;
					end
				end else if (tdone_q && !pop_valid) begin
					// Margin covers the drain, so the end stays in time
					pst_d = seep_pkg::PS_IDLE;
					busy_d = 1'b0;
				end
			end
			default: begin
				pst_d = seep_pkg::PS_IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	// Sequencer registers, frozen while the enable is low
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pst_q <= seep_pkg::PS_IDLE;
			stop_s_q <= 3'h0;
			fw_s_q <= 2'h0;
			timer_q <= '0;
			tdone_q <= 1'b0;
			idx_q <= 4'h0;
			busy_q <= 1'b0;
			prog_busy_out <= 1'b0;
		end else if (ce_in) begin
			pst_q <= pst_d;
			stop_s_q <= {stop_s_q[1:0], stop_tog_q};
			fw_s_q <= {fw_s_q[0], frame_wr_q};
			timer_q <= timer_d;
			tdone_q <= tdone_d;
			idx_q <= idx_d;
			busy_q <= busy_d;
			prog_busy_out <= busy_d;
		end
	end

	// Two-entry buffer; the writer stalls the page walk until cells settle
	seep_buf #(
		.WIDTH(ENTRY_W),
		.DEPTH(seep_pkg::BUF_DEPTH)
	) u_buf (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.in_valid_in(push_valid),
		.in_ready_out(push_ready),
		.in_data_in(push_data),
		.out_valid_out(pop_valid),
		.out_ready_in(pop_ready),
		.out_data_out(pop_data)
	);

	// Array write; protected frames never reach here
	always_ff @(posedge clk_in) begin
		if (ce_in && pop_valid && pop_ready) begin
			mem_q[pop_data[ENTRY_W-1:seep_pkg::DATA_W]] <= pop_data[seep_pkg::DATA_W-1:0];
		end
	end

endmodule

`default_nettype wire

// *** tb/seep_top_asserts.sv ***
// Purpose: Port checks of the serial EEPROM slave.
// Assumes: Serial clock far slower than clk_in.
// Notes: Bound to seep_top from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module seep_top_asserts #(
	parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES_DEF
) (
	// Clock, reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Two-wire bus
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	// Straps and status
	input wire logic dev_sel_bit0_pin_in,
	input wire logic dev_sel_bit1_pin_in,
	input wire logic dev_sel_bit2_pin_in,
	input wire logic wp_in,
	input wire logic prog_busy_out
);
	// ----------------------------------------------------------------
	// Busy length counter
	// ----------------------------------------------------------------
	logic [31:0] busy_cnt_q; // Cycles of the running program cycle
	logic [31:0] busy_cnt_d;
	always_comb begin
		busy_cnt_d = prog_busy_out ? busy_cnt_q + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			busy_cnt_q <= 32'h0;
		end else begin
			busy_cnt_q <= busy_cnt_d;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	chk_drain_only: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		sda_out == 1'b0) else $error("data line driven high");
	chk_oe_rise_low: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(sda_oe_out) |-> !scl_in) else $error("pull-down began with clock high");
	chk_oe_holds_high: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		scl_in && $past(scl_in) |-> $stable(sda_oe_out)) else $error("data moved with clock high");
	chk_busy_quiet: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		prog_busy_out && $past(prog_busy_out) |-> !sda_oe_out) else $error("answer while busy");
	chk_busy_bound: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		busy_cnt_q < PROG_CYCLES) else $error("program cycle too long");
	chk_busy_after_stop: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(prog_busy_out) |-> scl_in && sda_in) else $error("program start outside idle bus");
	chk_busy_wp_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(prog_busy_out) |-> !wp_in) else $error("program cycle while protected");
	chk_busy_min_len: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		$rose(prog_busy_out) |-> prog_busy_out[*8]) else $error("program cycle cut short");
endmodule
`default_nettype wire

// *** tb/seep_host_model.sv ***
// Purpose: Two-wire bus host model driving the serial EEPROM.
// Assumes: 160 ns bit time, phase unrelated to clk_in.
// Notes: Clock stands high between frames; line released means pull-up.
`timescale 1ns/1ps
`default_nettype none
module seep_host_model (
	// Bus drive
	output var logic scl_out,
	output var logic sda_low_out,
	input wire logic sda_in,
	// Observed results
	output var logic [7:0] res_out,
	output var logic res_tgl_out
);
	logic q = 1'b0; // Quarter-bit timebase
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
		res_out = 8'h00;
		res_tgl_out = 1'b0;
		#13;
		forever #20 q = ~q;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge q);
	endtask
	// One clock pulse, data set a quarter after the fall
	task automatic clk_bit(input logic low, output logic got);
		sda_low_out = low;
		tick(1);
		scl_out = 1'b1;
		tick(1);
		got = sda_in;
		tick(1);
		scl_out = 1'b0;
		tick(1);
	endtask
	task automatic bus_start();
		sda_low_out = 1'b0;
		tick(1);
		scl_out = 1'b1;
		tick(1);
		sda_low_out = 1'b1;
		tick(1);
		scl_out = 1'b0;
		tick(1);
	endtask
	task automatic bus_stop();
		sda_low_out = 1'b1;
		tick(1);
		scl_out = 1'b1;
		tick(1);
		sda_low_out = 1'b0;
		tick(6);
	endtask
	task automatic send_byte(input logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) clk_bit(~b[i], g);
		clk_bit(1'b0, g);
		res_out = {7'h00, g};
		res_tgl_out = ~res_tgl_out;
	endtask
	task automatic recv_byte(input logic last);
		logic g;
		logic [7:0] v;
		for (int i = 0; i < 8; i++) begin
			clk_bit(1'b0, g);
			v = {v[6:0], g};
		end
		clk_bit(~last, g);
		res_out = v;
		res_tgl_out = ~res_tgl_out;
	endtask
endmodule
`default_nettype wire

// *** tb/seep_top_tb_top.sv ***
// Purpose: Self-checking bench of the serial EEPROM slave.
// Assumes: Program cycle shortened to 64 clk_in cycles.
// Notes: Expected results queue up; a watcher compares them in order.
`timescale 1ns/1ps
`default_nettype none
module seep_top_tb_top;
	logic clk_in = 1'b0;
	logic arst_n_in; // Starts unknown so the first drive is an edge
	logic [2:0] straps = 3'h0; // Device select straps
	logic wp = 1'b0; // Write protect
	wire logic scl, host_low, host_tgl, sda_oe, sda_line, busy;
	wire logic [7:0] host_res;
	logic [7:0] exp_mem [256]; // Expected array contents
	logic [7:0] exp_q [$]; // Pending expected results
	logic [7:0] nxt = 8'h00; // Expected current address
	int n_fail = 0;
	int n_compared = 0;
	int seed = 68195;
	always #20 clk_in = ~clk_in;
	assign sda_line = ~(sda_oe | host_low); // Wired line with pull-up
	seep_top #(.PROG_CYCLES(64)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
		.scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
		.dev_sel_bit0_pin_in(straps[0]), .dev_sel_bit1_pin_in(straps[1]),
		.dev_sel_bit2_pin_in(straps[2]), .wp_in(wp), .prog_busy_out(busy));
	seep_host_model u_host (.scl_out(scl), .sda_low_out(host_low), .sda_in(sda_line),
		.res_out(host_res), .res_tgl_out(host_tgl));
	task automatic check_val(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic check_busy(input logic e);
		n_compared++;
		if (busy !== e) begin
			n_fail++;
			$display("wrong value at %0t: expected %h got %h", $time, e, busy);
		end
	endtask
	task automatic finish_test();
		if (exp_q.size() != 0) n_fail++;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Watcher takes the oldest note at each result
	// Result byte settles before it is read; power-up toggle is no result
	always @(host_tgl) begin
		#1;
		if (arst_n_in === 1'b1) begin
			if (exp_q.size() == 0) n_fail++;
			else check_val(exp_q.pop_front(), host_res);
		end
	end
	task automatic sel(input logic [2:0] s, input logic rd, input logic [7:0] ack);
		exp_q.push_back(ack);
		u_host.send_byte({seep_pkg::SEL_PREFIX, s, rd});
	endtask
	task automatic wr(input logic [7:0] a, input int n);
		logic [7:0] d;
		u_host.bus_start();
		sel(straps, 1'b0, 8'h00);
		exp_q.push_back(8'h00);
		u_host.send_byte(a);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			exp_q.push_back(8'h00);
			u_host.send_byte(d);
			if (wp === 1'b0) exp_mem[{a[7:3], a[2:0] + 3'(i)}] = d;
		end
		u_host.bus_stop();
		check_busy(~wp);
		if (wp === 1'b0) begin
			u_host.bus_start();
			sel(straps, 1'b0, 8'h01);
			u_host.bus_stop();
			for (int c = 0; c < 200 && busy !== 1'b0; c++) @(negedge clk_in);
			check_busy(1'b0);
		end
	endtask
	task automatic rd(input logic rnd, input logic [7:0] a, input int n);
		logic [7:0] p;
		p = rnd ? a : nxt;
		u_host.bus_start();
		if (rnd) begin
			sel(straps, 1'b0, 8'h00);
			exp_q.push_back(8'h00);
			u_host.send_byte(a);
			u_host.bus_start();
		end
		sel(straps, 1'b1, 8'h00);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(exp_mem[p]);
			u_host.recv_byte(i == n - 1);
			p++;
		end
		nxt = p;
		u_host.bus_stop();
	endtask
	// Main sequence
	initial begin
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1'b1;
		straps <= 3'($random(seed));
		@(posedge clk_in);
		for (int k = 0; k < 8; k++) begin
			u_host.bus_start();
			sel(3'(k), 1'b0, {7'h00, 3'(k) != straps});
			u_host.bus_stop();
		end
		wr(8'hfe, 10);
		wr(8'h00, 1);
		wr(8'hfa, 2);
		@(posedge clk_in) wp <= 1'b1;
		wr(8'hf9, 3);
		@(posedge clk_in) wp <= 1'b0;
		straps <= 3'h0;
		rd(1'b1, 8'hf8, 3);
		rd(1'b0, 8'h00, 1);
		rd(1'b1, 8'hff, 2);
		rd(1'b1, 8'hf8, 8);
		repeat (20) @(posedge clk_in);
		finish_test();
	end
	// Watchdog, far beyond the expected run
	initial begin
		#1000000;
		n_fail++;
		finish_test();
	end
endmodule
bind seep_top seep_top_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (.clk_in(clk_in),
	.arst_n_in(arst_n_in), .ce_in(ce_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .dev_sel_bit0_pin_in(dev_sel_bit0_pin_in),
	.dev_sel_bit1_pin_in(dev_sel_bit1_pin_in), .dev_sel_bit2_pin_in(dev_sel_bit2_pin_in),
	.wp_in(wp_in), .prog_busy_out(prog_busy_out));
`default_nettype wire
